// >>> common/ssr_pkg.sv
// constants and types shared by the serial port pin and clock router
package ssr_pkg;
    typedef logic [7:0] ssr_addr_t;
    typedef logic [31:0] ssr_data_t;

    // register byte offsets
    localparam ssr_addr_t REG_CTRL = 8'h00;
    localparam ssr_addr_t REG_CLKDIV = 8'h04;
    localparam ssr_addr_t REG_GPIO_OUT = 8'h08;
    localparam ssr_addr_t REG_GPIO_DIR = 8'h0c;
    localparam ssr_addr_t REG_STATUS = 8'h10;
    localparam ssr_addr_t REG_TX0 = 8'h14;
    localparam ssr_addr_t REG_TX1 = 8'h18;
    localparam ssr_addr_t REG_TX2 = 8'h1c;
    localparam ssr_addr_t REG_RX = 8'h20;

    // control register fields
    localparam int CTL_SYNC = 0;
    localparam int CTL_TXCLK_DIR = 1;
    localparam int CTL_C0_DIR = 2;
    localparam int CTL_C1_DIR = 3;
    localparam int CTL_C2_DIR = 4;
    localparam int CTL_OFLAG0 = 5;
    localparam int CTL_OFLAG1 = 6;
    localparam int CTL_TX0_EN = 7;
    localparam int CTL_TX1_EN = 8;
    localparam int CTL_TX2_EN = 9;
    localparam int CTL_RX_EN = 10;
    localparam int CTL_FLAG0_EN = 11;
    localparam int CTL_C1_SEL = 12;
    localparam int CTL_W = 14;
    localparam logic [CTL_W-1:0] CTL_RESET = 14'h0000;
    localparam logic [7:0] CLKDIV_RESET = 8'h01;

    // ctrl pin 1 selection in synchronous mode
    localparam logic [1:0] C1_SEL_FLAG = 2'h1;
    localparam logic [1:0] C1_SEL_DRV = 2'h2;

    // pin indices
    localparam int NPIN = 6;
    localparam int PIN_SCK = 0;
    localparam int PIN_C0 = 1;
    localparam int PIN_C1 = 2;
    localparam int PIN_C2 = 3;
    localparam int PIN_TD = 4;
    localparam int PIN_RD = 5;

    // serial word
    localparam int WORD_BITS = 8;
    localparam int NTX = 3;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // least half period count of the internal bit clock; a half period lasts this plus one core cycles
    localparam logic [7:0] MIN_HALF = 8'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        FN_GPIO = 3'b000,
        FN_CLK = 3'b001,
        FN_FSYNC = 3'b010,
        FN_DATA = 3'b011,
        FN_FLAG = 3'b100,
        FN_DRV = 3'b101
    } ssr_func_e;
endpackage : ssr_pkg

// >>> rtl/ssr_pin_sync.sv
// two-stage synchroniser for one pin with edge pulses
`timescale 1ns/1ns
module ssr_pin_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // first stage is read by the second only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~last_ff;
    assign fall = ~sync_ff & last_ff;
endmodule : ssr_pin_sync

// >>> rtl/ssr_port.sv
// serial port pin function routing, clock sources and shifters
// --------------------
// --------------------
`timescale 1ns/1ns
module ssr_port (
    input wire logic clock,
    input wire logic rst,
    input wire ssr_pkg::ssr_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire ssr_pkg::ssr_data_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire ssr_pkg::ssr_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output ssr_pkg::ssr_data_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ssr_pkg::NPIN-1:0] pin_in,
    output logic [ssr_pkg::NPIN-1:0] pin_out,
    output logic [ssr_pkg::NPIN-1:0] pin_oe
);
    import ssr_pkg::*;

    // --------------------
    // registers and decode
    // --------------------
    logic [CTL_W-1:0] ctrl_ff;
    logic [7:0] clkdiv_ff;
    logic [NPIN-1:0] gpio_out_ff;
    logic [NPIN-1:0] gpio_dir_ff;
    logic [WORD_BITS-1:0] tx_data_ff [NTX];
    logic [NTX-1:0] tx_pend_ff;
    logic [WORD_BITS-1:0] rx_data_ff;
    logic rx_full_ff;
    logic [NPIN-1:0] pin_out_ff;
    logic [NPIN-1:0] pin_oe_ff;

    function automatic logic [3:0] reg_index(input ssr_addr_t a);
        if (a[1:0] != 2'h0 || a > REG_RX) begin
            return 4'hf;
        end
        return a[5:2];
    endfunction : reg_index

    logic sync_mode;
    logic tx_clock_dir;
    logic any_en;
    logic [NTX-1:0] tx_en_eff;
    assign sync_mode = ctrl_ff[CTL_SYNC];
    assign tx_clock_dir = ctrl_ff[CTL_TXCLK_DIR];
    assign any_en = |ctrl_ff[CTL_RX_EN:CTL_TX0_EN];
    // asynchronous mode runs transmitter 0 alone
    assign tx_en_eff = {ctrl_ff[CTL_TX2_EN] & sync_mode,
                        ctrl_ff[CTL_TX1_EN] & sync_mode, ctrl_ff[CTL_TX0_EN]};

    // --------------------
    // pin input synchronisers
    // --------------------
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;

    // external clock edges are only seen at under half of core rate
    for (genvar p = 0; p < NPIN; p++) begin : g_sync
        ssr_pin_sync u_sync (
            .clock(clock),
            .rst(rst),
            .pin_in(pin_in[p]),
            .level(pin_lvl[p]),
            .rise(pin_rise[p]),
            .fall(pin_fall[p])
        );
    end

    // --------------------
    // pin function map
    // --------------------
    ssr_func_e fn [NPIN];
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            fn[i] = FN_GPIO;
        end
        if (!sync_mode) begin
            if (ctrl_ff[CTL_RX_EN]) begin
                fn[PIN_C0] = FN_CLK;
                fn[PIN_C1] = FN_FSYNC;
                fn[PIN_RD] = FN_DATA;
            end
            if (ctrl_ff[CTL_TX0_EN]) begin
                fn[PIN_C2] = FN_FSYNC;
                fn[PIN_SCK] = FN_CLK;
                fn[PIN_TD] = FN_DATA;
            end
        end else if (any_en) begin
            fn[PIN_SCK] = FN_CLK;
            fn[PIN_C2] = FN_FSYNC;
            if (tx_en_eff[0]) begin
                fn[PIN_TD] = FN_DATA;
            end
            if (ctrl_ff[CTL_RX_EN]) begin
                fn[PIN_RD] = FN_DATA;
            end
            if (tx_en_eff[1]) begin
                fn[PIN_C0] = FN_DATA;
            end else if (ctrl_ff[CTL_FLAG0_EN]) begin
                fn[PIN_C0] = FN_FLAG;
            end
            if (tx_en_eff[2]) begin
                fn[PIN_C1] = FN_DATA;
            end else if (ctrl_ff[CTL_C1_SEL+1:CTL_C1_SEL] == C1_SEL_FLAG) begin
                fn[PIN_C1] = FN_FLAG;
            end else if (ctrl_ff[CTL_C1_SEL+1:CTL_C1_SEL] == C1_SEL_DRV) begin
                fn[PIN_C1] = FN_DRV;
            end
        end
    end

    // --------------------
    // internal bit clock generator
    // --------------------
    logic [7:0] half_cnt_ff;
    logic sck_int_ff;
    logic [7:0] half_max;
    logic int_toggle;
    logic int_run;
    // a half period never below two core cycles keeps it at a quarter
    assign half_max = (clkdiv_ff < MIN_HALF) ? MIN_HALF : clkdiv_ff;
    assign int_run = any_en & (tx_clock_dir | (~sync_mode & ctrl_ff[CTL_C0_DIR]));
    assign int_toggle = int_run && (half_cnt_ff == half_max);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            half_cnt_ff <= 8'h00;
            sck_int_ff <= 1'b0;
        end else if (!int_run) begin
            half_cnt_ff <= 8'h00;
            sck_int_ff <= 1'b0;
        end else if (int_toggle) begin
            half_cnt_ff <= 8'h00;
            sck_int_ff <= ~sck_int_ff;
        end else begin
            half_cnt_ff <= half_cnt_ff + 8'h01;
        end
    end

    // --------------------
    // clock source selection
    // --------------------
    logic tx_edge;
    logic rx_edge;
    logic rx_clk_int;
    // transmit on rising edges, receive on falling edges
    assign tx_edge = tx_clock_dir ? (int_toggle & ~sck_int_ff) : pin_rise[PIN_SCK];
    assign rx_clk_int = sync_mode ? tx_clock_dir : ctrl_ff[CTL_C0_DIR];
    always_comb begin
        if (rx_clk_int) begin
            rx_edge = int_toggle & sck_int_ff;
        end else if (sync_mode) begin
            rx_edge = pin_fall[PIN_SCK];
        end else begin
            rx_edge = pin_fall[PIN_C0];
        end
    end

    // --------------------
    // transmitters, all shifting in step
    // --------------------
    logic tx_active_ff;
    logic [2:0] tx_bit_ff;
    logic [WORD_BITS-1:0] tx_shift_ff [NTX];
    logic tx_fs_ok;
    logic tx_start;
    logic tx_shift;
    logic [NTX-1:0] tx_load;
    // an external frame sync gates the start of a word
    assign tx_fs_ok = ctrl_ff[CTL_C2_DIR] | pin_lvl[PIN_C2];
    assign tx_start = tx_edge && (!tx_active_ff || tx_bit_ff == LAST_BIT)
                      && |(tx_pend_ff & tx_en_eff) && tx_fs_ok;
    assign tx_shift = tx_edge && tx_active_ff && tx_bit_ff != LAST_BIT;
    assign tx_load = tx_start ? (tx_pend_ff & tx_en_eff) : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_active_ff <= 1'b0;
            tx_bit_ff <= 3'h0;
        end else if (tx_start) begin
            tx_active_ff <= 1'b1;
            tx_bit_ff <= 3'h0;
        end else if (tx_shift) begin
            tx_bit_ff <= tx_bit_ff + 3'h1;
        end else if (tx_edge && tx_active_ff) begin
            // no word follows: with an internal clock, release the data line for a whole period
            tx_active_ff <= 1'b0;
        end
    end

    for (genvar t = 0; t < NTX; t++) begin : g_tx
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                tx_shift_ff[t] <= '0;
            end else if (tx_start) begin
                // a transmitter without fresh data sends zeros
                tx_shift_ff[t] <= tx_load[t] ? tx_data_ff[t] : '0;
            end else if (tx_shift) begin
                tx_shift_ff[t] <= {tx_shift_ff[t][WORD_BITS-2:0], 1'b0};
            end
        end
    end

    // --------------------
    // receiver
    // --------------------
    logic [2:0] rx_bit_ff;
    logic [WORD_BITS-1:0] rx_shift_ff;
    logic rx_fs_pin_in;
    logic rx_fs_ext;
    logic rx_done;
    // frame sync for the receiver: ctrl pin 2 when synchronous, pin 1 when not
    assign rx_fs_pin_in = sync_mode ? ~ctrl_ff[CTL_C2_DIR] : ~ctrl_ff[CTL_C1_DIR];
    assign rx_fs_ext = rx_fs_pin_in & (sync_mode ? pin_lvl[PIN_C2] : pin_lvl[PIN_C1]);
    assign rx_done = rx_edge && ctrl_ff[CTL_RX_EN] && !rx_fs_ext && rx_bit_ff == LAST_BIT;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_bit_ff <= 3'h0;
            rx_shift_ff <= '0;
        end else if (!ctrl_ff[CTL_RX_EN]) begin
            rx_bit_ff <= 3'h0;
        end else if (rx_edge) begin
            rx_shift_ff <= {rx_shift_ff[WORD_BITS-2:0], pin_lvl[PIN_RD]};
            rx_bit_ff <= rx_fs_ext ? 3'h1 : rx_bit_ff + 3'h1;
        end
    end

    // --------------------
    // pin drivers
    // --------------------
    logic [NPIN-1:0] nxt_pin_out;
    logic [NPIN-1:0] nxt_pin_oe;
    logic fs_int;
    assign fs_int = tx_active_ff && tx_bit_ff == 3'h0;

    always_comb begin
        nxt_pin_out = gpio_out_ff;
        nxt_pin_oe = gpio_dir_ff;
        nxt_pin_oe[PIN_RD] = (fn[PIN_RD] == FN_GPIO) & gpio_dir_ff[PIN_RD];
        if (fn[PIN_SCK] == FN_CLK) begin
            nxt_pin_out[PIN_SCK] = sck_int_ff;
            nxt_pin_oe[PIN_SCK] = tx_clock_dir;
        end
        case (fn[PIN_C0])
            FN_CLK: begin
                nxt_pin_out[PIN_C0] = sck_int_ff;
                nxt_pin_oe[PIN_C0] = ctrl_ff[CTL_C0_DIR];
            end
            FN_FLAG: begin
                nxt_pin_out[PIN_C0] = ctrl_ff[CTL_OFLAG0];
                nxt_pin_oe[PIN_C0] = ctrl_ff[CTL_C0_DIR];
            end
            FN_DATA: begin
                nxt_pin_out[PIN_C0] = tx_shift_ff[1][WORD_BITS-1];
                nxt_pin_oe[PIN_C0] = 1'b1;
            end
            default: begin
            end
        endcase
        case (fn[PIN_C1])
            FN_FSYNC: begin
                nxt_pin_out[PIN_C1] = ctrl_ff[CTL_RX_EN] && rx_bit_ff == 3'h0;
                nxt_pin_oe[PIN_C1] = ctrl_ff[CTL_C1_DIR];
            end
            FN_FLAG: begin
                nxt_pin_out[PIN_C1] = ctrl_ff[CTL_OFLAG1];
                nxt_pin_oe[PIN_C1] = ctrl_ff[CTL_C1_DIR];
            end
            FN_DRV: begin
                nxt_pin_out[PIN_C1] = tx_active_ff;
                nxt_pin_oe[PIN_C1] = 1'b1;
            end
            FN_DATA: begin
                nxt_pin_out[PIN_C1] = tx_shift_ff[2][WORD_BITS-1];
                nxt_pin_oe[PIN_C1] = 1'b1;
            end
            default: begin
            end
        endcase
        if (fn[PIN_C2] == FN_FSYNC) begin
            nxt_pin_out[PIN_C2] = fs_int;
            nxt_pin_oe[PIN_C2] = ctrl_ff[CTL_C2_DIR];
        end
        if (fn[PIN_TD] == FN_DATA) begin
            nxt_pin_out[PIN_TD] = tx_shift_ff[0][WORD_BITS-1];
            // only an internal clock lets the line float between words
            nxt_pin_oe[PIN_TD] = tx_active_ff | ~tx_clock_dir;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
        end
    end
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;

    // --------------------
    // bus slave
    // --------------------
    logic aw_got_ff;
    logic w_got_ff;
    ssr_addr_t aw_addr_ff;
    ssr_data_t w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    ssr_data_t rdata_ff;
    logic [1:0] rresp_ff;
    logic do_write;
    logic do_read;
    logic [3:0] widx;
    logic [3:0] ridx;
    logic rx_read;

    assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
    assign do_read = s_axi_arvalid & ~rvalid_ff;
    assign widx = reg_index(aw_addr_ff);
    assign ridx = reg_index(s_axi_araddr);
    assign rx_read = do_read && ridx == REG_RX[5:2];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_data_ff <= '0;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (widx == 4'hf || widx == REG_STATUS[5:2]
                             || widx == REG_RX[5:2]) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTL_RESET;
            clkdiv_ff <= CLKDIV_RESET;
            gpio_out_ff <= '0;
            gpio_dir_ff <= '0;
        end else if (do_write) begin
            case (widx)
                REG_CTRL[5:2]: begin
                    if (w_strb_ff[0]) ctrl_ff[7:0] <= w_data_ff[7:0];
                    if (w_strb_ff[1]) ctrl_ff[CTL_W-1:8] <= w_data_ff[CTL_W-1:8];
                end
                REG_CLKDIV[5:2]: if (w_strb_ff[0]) clkdiv_ff <= w_data_ff[7:0];
                REG_GPIO_OUT[5:2]: if (w_strb_ff[0]) gpio_out_ff <= w_data_ff[NPIN-1:0];
                REG_GPIO_DIR[5:2]: if (w_strb_ff[0]) gpio_dir_ff <= w_data_ff[NPIN-1:0];
                default: begin
                end
            endcase
        end
    end

    // data writes mark a word pending; a write in the load cycle wins
    for (genvar t = 0; t < NTX; t++) begin : g_txreg
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                tx_data_ff[t] <= '0;
                tx_pend_ff[t] <= 1'b0;
            end else if (do_write && w_strb_ff[0]
                         && widx == REG_TX0[5:2] + 4'(t)) begin
                tx_data_ff[t] <= w_data_ff[WORD_BITS-1:0];
                tx_pend_ff[t] <= 1'b1;
            end else if (tx_load[t]) begin
                tx_pend_ff[t] <= 1'b0;
            end
        end
    end

    // a word landing in the read cycle keeps the full flag set
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_data_ff <= '0;
            rx_full_ff <= 1'b0;
        end else if (rx_done) begin
            rx_data_ff <= {rx_shift_ff[WORD_BITS-2:0], pin_lvl[PIN_RD]};
            rx_full_ff <= 1'b1;
        end else if (rx_read) begin
            rx_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (do_read) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
            case (ridx)
                REG_CTRL[5:2]: rdata_ff[CTL_W-1:0] <= ctrl_ff;
                REG_CLKDIV[5:2]: rdata_ff[7:0] <= clkdiv_ff;
                REG_GPIO_OUT[5:2]: rdata_ff[NPIN-1:0] <= gpio_out_ff;
                REG_GPIO_DIR[5:2]: rdata_ff[NPIN-1:0] <= gpio_dir_ff;
                REG_STATUS[5:2]: begin
                    // flag inputs follow the pin whenever it is an input flag
                    rdata_ff[0] <= (fn[PIN_C0] == FN_FLAG) & pin_lvl[PIN_C0];
                    rdata_ff[1] <= (fn[PIN_C1] == FN_FLAG) & pin_lvl[PIN_C1];
                    rdata_ff[2] <= rx_full_ff;
                    rdata_ff[3] <= tx_active_ff;
                    rdata_ff[6:4] <= tx_pend_ff;
                    rdata_ff[13:8] <= pin_lvl;
                end
                REG_TX0[5:2]: rdata_ff[WORD_BITS-1:0] <= tx_data_ff[0];
                REG_TX1[5:2]: rdata_ff[WORD_BITS-1:0] <= tx_data_ff[1];
                REG_TX2[5:2]: rdata_ff[WORD_BITS-1:0] <= tx_data_ff[2];
                REG_RX[5:2]: rdata_ff[WORD_BITS-1:0] <= rx_data_ff;
                default: rresp_ff <= RESP_SLVERR;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule : ssr_port

// >>> test/ssr_port_assertions.sv
// bound checker on the serial port router ports
`timescale 1ns/1ns
module ssr_port_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire ssr_pkg::ssr_data_t s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ssr_pkg::NPIN-1:0] pin_out,
    input wire logic [ssr_pkg::NPIN-1:0] pin_oe
);
    import ssr_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence sck_up;
        pin_oe[PIN_SCK] && $rose(pin_out[PIN_SCK]);
    endsequence
    sequence sck_dn;
        pin_oe[PIN_SCK] && $fell(pin_out[PIN_SCK]);
    endsequence
    AST_WR_ANS: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer off");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    // a one cycle phase would put the bit clock above quarter core rate
    AST_SCK_HIGH: assert property (sck_up |=> pin_out[PIN_SCK] || !pin_oe[PIN_SCK])
        else $error("bit clock high too short");
    AST_SCK_LOW: assert property (sck_dn |=> !pin_out[PIN_SCK] || !pin_oe[PIN_SCK])
        else $error("bit clock low too short");
endmodule : ssr_port_assertions

bind ssr_port ssr_port_assertions ssr_port_assertions_inst (.*);

// >>> test/ssr_far_end.sv
// far end model: bit clock, frame sync, flag and data loopback
`timescale 1ns/1ns
module ssr_far_end (
    input wire logic link_clk,
    input wire logic run,
    input wire logic flag,
    input wire logic [ssr_pkg::NPIN-1:0] pin_out,
    input wire logic [ssr_pkg::NPIN-1:0] pin_oe,
    output logic [ssr_pkg::NPIN-1:0] pin_in
);
    import ssr_pkg::*;
    logic sck;
    logic fell_ff;
    // gated so it stands still between frames; eighth of core rate
    assign sck = run & link_clk;
    always @(negedge sck or negedge run) begin
        if (!run) begin
            fell_ff <= 1'b0;
        end else begin
            fell_ff <= 1'b1;
        end
    end
    always_comb begin
        // released lines read back inverted, never the last value
        pin_in = pin_out ~^ pin_oe;
        if (!pin_oe[PIN_SCK]) pin_in[PIN_SCK] = sck;
        if (!pin_oe[PIN_C0]) pin_in[PIN_C0] = flag;
        if (!pin_oe[PIN_C2]) pin_in[PIN_C2] = run && !fell_ff;
        if (!pin_oe[PIN_RD]) pin_in[PIN_RD] = pin_out[PIN_TD] ~^ pin_oe[PIN_TD];
    end
endmodule : ssr_far_end

// >>> test/tb.sv
// self-checking bench for the serial port router
`timescale 1ns/1ns
module tb;
    import ssr_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic link_clk = 1'b0;
    logic run = 1'b0;
    logic flag = 1'b0;
    ssr_addr_t s_axi_awaddr = '0;
    ssr_addr_t s_axi_araddr = '0;
    ssr_data_t s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ssr_data_t s_axi_rdata;
    logic [NPIN-1:0] pin_in, pin_out, pin_oe;
    int err_total = 0;
    int compares = 0;
    ssr_port ssr_port_inst (.*);
    ssr_far_end ssr_far_end_inst (.*);
    always #20 clock = ~clock;
    initial #7 forever #160 link_clk = ~link_clk;
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic guard(inout int n);
        n++;
        if (n > 400) begin
            err_total++;
            final_report();
        end
    endtask : guard
    task automatic wr(input ssr_addr_t a, input ssr_data_t d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            guard(n);
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b1;
        @(posedge clock);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input ssr_addr_t a, output ssr_data_t d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            guard(n);
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b1;
        @(posedge clock);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic fall_wait(output int c);
        logic p;
        c = 0;
        do begin
            p = pin_out[PIN_SCK];
            @(negedge clock);
            guard(c);
        end while (!(p && !pin_out[PIN_SCK]));
    endtask : fall_wait
    function automatic int per(input int dv);
        return 2 * ((dv < 1 ? 1 : dv) + 1);
    endfunction : per
    initial begin
        logic [1:0] r;
        ssr_data_t d, v, w [3], x [3];
        int c, dv;
        d = $urandom(32'h2ae2);
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(ssr_addr_t'(4 * i), d, r);
            check("reset value", d, 32'(i == 1));
        end
        rd(8'h40, d, r);
        check("unmapped data", d, 32'h0);
        check("unmapped resp", r, RESP_SLVERR);
        wr(REG_STATUS, 32'h0, r);
        check("status write", r, RESP_SLVERR);
        // idle, async tx1/tx2 only, sync idle: all general I/O
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr(REG_CTRL, i % 3 == 0 ? 32'h0 : (i % 3 == 1 ? 32'h300 : 32'h1), r);
            wr(REG_GPIO_OUT, v, r);
            wr(REG_GPIO_DIR, v >> 8, r);
            repeat (3) @(negedge clock);
            check("gpio oe", pin_oe, v[13:8]);
            check("gpio out", pin_out & pin_oe, v[5:0] & v[13:8]);
        end
        // random drive enables would otherwise linger on the serial pins
        wr(REG_GPIO_DIR, 32'h0, r);
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            flag <= v[1];
            wr(REG_CTRL, 32'hc05 | 32'(v[0]) << CTL_OFLAG0, r);
            repeat (3) @(negedge clock);
            check("flag out", {pin_oe[PIN_C0], pin_out[PIN_C0]}, {1'b1, v[0]});
            wr(REG_CTRL, 32'hc01, r);
            repeat (4) @(negedge clock);
            rd(REG_STATUS, d, r);
            check("flag in", {pin_oe[PIN_C0], d[0]}, {1'b0, v[1]});
        end
        // divider 0 still gives a quarter-rate clock
        for (int k = 0; k < 2; k++) begin
            dv = k * (1 + $urandom % 5);
            wr(REG_CLKDIV, dv, r);
            foreach (w[j]) begin
                w[j] = $urandom % 256;
                wr(REG_TX0 + 8'(4 * j), w[j], r);
            end
            wr(REG_CTRL, 32'h393, r);
            c = 0;
            do begin
                @(negedge clock);
                guard(c);
            end while (pin_out[PIN_C2] !== 1'b1);
            check("pins driven", pin_oe[4:0], 5'h1f);
            for (int b = 0; b < 9; b++) begin
                fall_wait(c);
                if (b > 0) check("period", c, per(dv));
                if (b < 8) foreach (x[j]) x[j] = {x[j][30:0], pin_out[j == 0 ? PIN_TD : j]};
            end
            foreach (x[j]) check("word", x[j][7:0], w[j]);
            check("td release", pin_oe[PIN_TD], 1'b0);
            wr(REG_CTRL, 32'h0, r);
        end
        v = $urandom % 256;
        wr(REG_TX0, v, r);
        wr(REG_CTRL, 32'h481, r);
        @(negedge link_clk);
        run <= 1'b1;
        c = 0;
        do begin
            rd(REG_STATUS, d, r);
            guard(c);
        end while (d[2] !== 1'b1);
        rd(REG_RX, d, r);
        check("loopback", d, v);
        check("sck oe", pin_oe[PIN_SCK], 1'b0);
        @(negedge link_clk);
        run <= 1'b0;
        final_report();
    end
endmodule : tb
